//--- design/pll_device.sv
// Behavioural PLL device end with configuration checks and lock tracking.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module pll_device
    import pll_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    pll_link_if.device      link,
    input  wire src_mode_e  src_mode,
    input  wire fb_mode_e   fb_mode,
    input  wire logic [1:0] fb_select,
    input  wire logic [7:0] mult_m,
    input  wire logic [3:0] pre_n,
    input  wire logic [3:0] post_o,
    input  wire logic [8:0] div_c,
    input  wire logic [2:0] out_enable,
    input  wire phase_e     phase_a,
    output logic            config_ok,
    output logic            phase_aligned,
    output logic [1:0]      active_source
);

    // Synchronisers for every clock arriving on pins.
    logic [REF_COUNT-1:0] ref_s1_ff;
    logic [REF_COUNT-1:0] ref_s2_ff;
    logic [SEL_W-1:0]     sel_s1_ff;
    logic [SEL_W-1:0]     sel_s2_ff;
    logic                 rst_s1_ff;
    logic                 rst_s2_ff;
    logic                 fbk_s1_ff;
    logic                 fbk_s2_ff;

    // Lock tracking state.
    logic                 ref_last_ff;
    logic [CNT_W-1:0]     gap_cnt_ff;
    logic [CNT_W-1:0]     lock_cnt_ff;
    logic                 locked_ff;
    logic [1:0]           src_idx_ff;
    logic [8:0]           div_cnt_ff;
    logic                 out_tog_ff;
    logic                 out_d1_ff;
    logic                 out_d2_ff;
    logic                 aligned_ff;
    logic                 ok_ff;

    logic [1:0]           nxt_src_idx;
    logic                 ref_now;
    logic                 ref_edge;
    logic                 ref_running;
    logic                 post_ok;
    logic                 phase_ok;
    logic                 fb_ok;
    logic                 nxt_ok;

    // Two-flop synchronisers on all link inputs.
    always_ff @(posedge clk) begin
        if (srst) begin
            ref_s1_ff <= '0;
            ref_s2_ff <= '0;
            sel_s1_ff <= '0;
            sel_s2_ff <= '0;
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
            fbk_s1_ff <= 1'b0;
            fbk_s2_ff <= 1'b0;
        end else begin
            ref_s1_ff <= link.ref_clk_in;
            ref_s2_ff <= ref_s1_ff;
            sel_s1_ff <= link.ref_clk_select;
            sel_s2_ff <= sel_s1_ff;
            rst_s1_ff <= link.pll_reset_n;
            rst_s2_ff <= rst_s1_ff;
            fbk_s1_ff <= link.core_feedback_clk;
            fbk_s2_ff <= fbk_s1_ff;
        end
    end

    // Source index from the configured source mode.
    always_comb begin
        unique case (src_mode)
            SRC_EXTERNAL: nxt_src_idx = EXT_PAD_IDX;
            SRC_CORE:     nxt_src_idx = CORE_CLK_IDX;
            SRC_DYNAMIC:  nxt_src_idx = sel_s2_ff;
            default:      nxt_src_idx = EXT_PAD_IDX;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            src_idx_ff <= '0;
        end else begin
            src_idx_ff <= nxt_src_idx;
        end
    end

    assign ref_now  = ref_s2_ff[src_idx_ff];
    assign ref_edge = ref_now & ~ref_last_ff;
    assign ref_running = (gap_cnt_ff < CNT_W'(REF_GAP_CYC));

    // Watch the chosen reference for edges and for silence.
    always_ff @(posedge clk) begin
        if (srst) begin
            ref_last_ff <= 1'b0;
            gap_cnt_ff  <= CNT_W'(REF_GAP_CYC);
        end else begin
            ref_last_ff <= ref_now;
            if (ref_edge) begin
                gap_cnt_ff <= '0;
            end else if (ref_running) begin
                gap_cnt_ff <= gap_cnt_ff + 1'b1;
            end
        end
    end

    // Divider settings checked against their legal ranges.
    assign post_ok = (post_o == POST_1) || (post_o == POST_2) ||
                     (post_o == POST_4) || (post_o == POST_8);
    always_comb begin
        unique case (phase_a)
            PH_0:    phase_ok = 1'b1;
            PH_45:   phase_ok = (div_c == CDIV_4);
            PH_90:   phase_ok = (div_c == CDIV_2) || (div_c == CDIV_4) ||
                                (div_c == CDIV_6);
            PH_135:  phase_ok = (div_c == CDIV_4);
            PH_180:  phase_ok = (div_c == CDIV_2);
            PH_270:  phase_ok = (div_c == CDIV_2);
            default: phase_ok = 1'b0;
        endcase
    end
    // Core feedback must come from an enabled output clock.
    assign fb_ok = (fb_mode != FB_CORE) ||
                   ((fb_select < 2'h3) && out_enable[fb_select]);
    assign nxt_ok = (mult_m >= MULT_MIN) && (mult_m <= MULT_MAX) &&
                    (pre_n >= PRE_MIN) && (pre_n <= PRE_MAX) && post_ok &&
                    (div_c >= OUT_MIN) && (div_c <= OUT_MAX) &&
                    !(($countones(out_enable) > 1) && (post_o == POST_1)) &&
                    phase_ok && fb_ok;

    always_ff @(posedge clk) begin
        if (srst) begin
            ok_ff <= 1'b0;
        end else begin
            ok_ff <= nxt_ok;
        end
    end

    // Lock: counts steady reference edges while out of reset.
    always_ff @(posedge clk) begin
        if (srst || !rst_s2_ff || !ok_ff) begin
            lock_cnt_ff <= '0;
            locked_ff   <= 1'b0;
        end else if (!ref_running) begin
            lock_cnt_ff <= lock_cnt_ff;
            locked_ff   <= locked_ff;
        end else if (ref_edge && lock_cnt_ff < CNT_W'(LOCK_CYC)) begin
            lock_cnt_ff <= lock_cnt_ff + 1'b1;
        end else if (lock_cnt_ff == CNT_W'(LOCK_CYC)) begin
            locked_ff <= 1'b1;
        end
    end

    // Output divider model running from the reference while locked.
    always_ff @(posedge clk) begin
        if (srst || !locked_ff) begin
            div_cnt_ff <= '0;
            out_tog_ff <= 1'b0;
        end else if (ref_edge) begin
            if (div_cnt_ff + 9'h001 >= div_c) begin
                div_cnt_ff <= '0;
                out_tog_ff <= ~out_tog_ff;
            end else begin
                div_cnt_ff <= div_cnt_ff + 9'h001;
            end
        end
    end

    // Output clock delayed by two flops to match the feedback synchroniser.
    always_ff @(posedge clk) begin
        if (srst) begin
            out_d1_ff <= 1'b0;
            out_d2_ff <= 1'b0;
        end else begin
            out_d1_ff <= out_tog_ff;
            out_d2_ff <= out_d1_ff;
        end
    end

    // Phase alignment claim depends on feedback mode.
    always_ff @(posedge clk) begin
        if (srst) begin
            aligned_ff <= 1'b0;
        end else begin
            unique case (fb_mode)
                FB_INTERNAL: aligned_ff <= 1'b0;
                FB_LOCAL:    aligned_ff <= locked_ff;
                FB_CORE:     aligned_ff <= locked_ff & fb_ok &
                                           (fbk_s2_ff == out_d2_ff);
                default:     aligned_ff <= 1'b0;
            endcase
        end
    end

    // Each output clock gated by its own enable.
    assign link.pll_out_clk_a = out_tog_ff & out_enable[0];
    assign link.pll_out_clk_b = out_tog_ff & out_enable[1];
    assign link.pll_out_clk_c = out_tog_ff & out_enable[2];
    assign link.pll_locked    = locked_ff;
    assign config_ok          = ok_ff;
    assign phase_aligned      = aligned_ff;
    assign active_source      = src_idx_ff;

endmodule : pll_device

//--- design/pll_pkg.sv
// Shared constants and types for the PLL fabric interface.
package pll_pkg;

    // Reference clock inputs and select width.
    localparam int unsigned REF_COUNT = 4;
    localparam int unsigned SEL_W     = 2;

    // Clock timing.
    localparam int unsigned CLK_PERIOD_NS = 40;

    // Least reset pulse in nanoseconds and in whole cycles (rounded up).
    localparam int unsigned RESET_MIN_NS = 10;
    localparam int unsigned RESET_MIN_CYC_RAW =
        (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RESET_MIN_CYC =
        (RESET_MIN_CYC_RAW < 1) ? 1 : RESET_MIN_CYC_RAW;

    // Cycles that the chosen reference must run before reset is released.
    localparam int unsigned REF_SETTLE_CYC = 8;

    // Cycles of steady reference edges before lock is declared.
    localparam int unsigned LOCK_CYC = 16;
    localparam int unsigned CNT_W    = 8;

    // Reference silence in cycles after which lock level is frozen.
    localparam int unsigned REF_GAP_CYC = 6;

    // Divider ranges.
    localparam logic [7:0] MULT_MIN = 8'h01;
    localparam logic [7:0] MULT_MAX = 8'hff;
    localparam logic [3:0] PRE_MIN  = 4'h1;
    localparam logic [3:0] PRE_MAX  = 4'hf;
    localparam logic [8:0] OUT_MIN  = 9'h001;
    localparam logic [8:0] OUT_MAX  = 9'h100;

    // Post divider encodings 1, 2, 4, 8.
    localparam logic [3:0] POST_1 = 4'h1;
    localparam logic [3:0] POST_2 = 4'h2;
    localparam logic [3:0] POST_4 = 4'h4;
    localparam logic [3:0] POST_8 = 4'h8;

    // Output divider values that allow a phase shift.
    localparam logic [8:0] CDIV_2 = 9'h002;
    localparam logic [8:0] CDIV_4 = 9'h004;
    localparam logic [8:0] CDIV_6 = 9'h006;

    // Phase shift codes.
    typedef enum logic [2:0] {
        PH_0, PH_45, PH_90, PH_135, PH_180, PH_270
    } phase_e;

    // Reference source modes.
    typedef enum logic [1:0] {
        SRC_EXTERNAL, SRC_CORE, SRC_DYNAMIC
    } src_mode_e;

    // Feedback modes.
    typedef enum logic [1:0] {
        FB_INTERNAL, FB_LOCAL, FB_CORE
    } fb_mode_e;

    // Fixed-source indices for external pad and core clock.
    localparam logic [1:0] EXT_PAD_IDX  = 2'h0;
    localparam logic [1:0] CORE_CLK_IDX = 2'h3;

endpackage : pll_pkg

//--- design/pll_link_if.sv
// Interface joining the PLL device end and the controlling fabric end.
`timescale 1ns/1ps
interface pll_link_if;
    import pll_pkg::*;

    logic [REF_COUNT-1:0] ref_clk_in;
    logic [SEL_W-1:0]     ref_clk_select;
    logic                 pll_reset_n;
    logic                 core_feedback_clk;
    logic                 pll_locked;
    logic                 pll_out_clk_a;
    logic                 pll_out_clk_b;
    logic                 pll_out_clk_c;

    // Device end: the PLL model.
    modport device (
        input  ref_clk_in,
        input  ref_clk_select,
        input  pll_reset_n,
        input  core_feedback_clk,
        output pll_locked,
        output pll_out_clk_a,
        output pll_out_clk_b,
        output pll_out_clk_c
    );

    // Fabric end: drives select, reset and feedback, watches lock.
    modport fabric (
        output ref_clk_select,
        output pll_reset_n,
        output core_feedback_clk,
        input  pll_locked,
        input  pll_out_clk_a,
        input  pll_out_clk_b,
        input  pll_out_clk_c
    );
endinterface : pll_link_if

//--- design/pll_fabric_ctrl.sv
// Fabric end: sequences PLL reset and select, synchronises lock, APB regs.
`timescale 1ns/1ps
module pll_fabric_ctrl
    import pll_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    pll_link_if.fabric       link,
    input  wire logic [REF_COUNT-1:0] ref_clk_src,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);

    // Register offsets of the control block.
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam int unsigned RUN_BIT    = 0;
    localparam int unsigned FB_BIT     = 1;
    localparam int unsigned SEL_LSB    = 4;

    typedef enum logic [1:0] {ST_HOLD, ST_SETTLE, ST_RUN} seq_e;

    logic [SEL_W-1:0] sel_req_ff;
    logic [SEL_W-1:0] sel_ff;
    logic             run_ff;
    logic             fb_src_ff;
    logic             pll_reset_n_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic             lock_s1_ff;
    logic             lock_s2_ff;
    logic [31:0]      rdata_ff;
    seq_e             state_ff;
    logic             wr_en;
    logic             rd_en;
    logic             addr_ok;

    assign addr_ok = (paddr == CTRL_OFS) || (paddr == STATUS_OFS);
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~penable & ~pwrite;

    // Control register writes.
    always_ff @(posedge clk) begin
        if (srst) begin
            run_ff     <= 1'b0;
            fb_src_ff  <= 1'b0;
            sel_req_ff <= '0;
        end else if (wr_en && paddr == CTRL_OFS) begin
            run_ff     <= pwdata[RUN_BIT];
            fb_src_ff  <= pwdata[FB_BIT];
            sel_req_ff <= pwdata[SEL_LSB +: SEL_W];
        end
    end

    // Reset sequencer: select changes only while reset is held.
    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= ST_HOLD;
            cnt_ff   <= '0;
            pll_reset_n_ff  <= 1'b0;
            sel_ff   <= '0;
        end else begin
            unique case (state_ff)
                ST_HOLD: begin
                    pll_reset_n_ff <= 1'b0;
                    sel_ff  <= sel_req_ff;
                    cnt_ff  <= '0;
                    if (run_ff) begin
                        state_ff <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    cnt_ff <= cnt_ff + 1'b1;
                    if (!run_ff || sel_req_ff != sel_ff) begin
                        state_ff <= ST_HOLD;
                    end else if (cnt_ff >= CNT_W'(REF_SETTLE_CYC) &&
                                 cnt_ff >= CNT_W'(RESET_MIN_CYC)) begin
                        pll_reset_n_ff  <= 1'b1;
                        state_ff <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!run_ff || sel_req_ff != sel_ff) begin
                        pll_reset_n_ff  <= 1'b0;
                        state_ff <= ST_HOLD;
                    end
                end
            endcase
        end
    end

    // Lock passes two flops before any logic reads it.
    always_ff @(posedge clk) begin
        if (srst) begin
            lock_s1_ff <= 1'b0;
            lock_s2_ff <= 1'b0;
        end else begin
            lock_s1_ff <= link.pll_locked;
            lock_s2_ff <= lock_s1_ff;
        end
    end

    // Read data captured in the setup cycle.
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_ff <= '0;
        end else if (rd_en) begin
            unique case (paddr)
                CTRL_OFS:   rdata_ff <= {26'h0, sel_req_ff, 2'h0,
                                         fb_src_ff, run_ff};
                STATUS_OFS: rdata_ff <= {27'h0, sel_ff, pll_reset_n_ff,
                                         state_ff == ST_RUN, lock_s2_ff};
                default:    rdata_ff <= '0;
            endcase
        end
    end

    assign link.ref_clk_select    = sel_ff;
    assign link.pll_reset_n       = pll_reset_n_ff;
    // Core feedback from output a, or output b when chosen.
    assign link.core_feedback_clk = fb_src_ff ? link.pll_out_clk_b
                                              : link.pll_out_clk_a;
    assign prdata  = rdata_ff;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

endmodule : pll_fabric_ctrl

//--- testbench/pll_link_properties.sv
// Concurrent checks on the link between the PLL device and fabric ends.
`timescale 1ns/1ps
module pll_link_properties
    import pll_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 srst,
    input wire logic [REF_COUNT-1:0] ref_clk_in,
    input wire logic [SEL_W-1:0]     ref_clk_select,
    input wire logic                 pll_reset_n,
    input wire logic                 core_feedback_clk,
    input wire logic                 pll_locked,
    input wire logic                 pll_out_clk_a,
    input wire logic                 pll_out_clk_b,
    input wire logic                 pll_out_clk_c
);
    logic [7:0] low_cnt_ff;
    logic [7:0] gap_cnt_ff;
    logic       ref_prev_ff;
    logic       ref_sel;

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    // Selected reference as it stands on the link.
    assign ref_sel = ref_clk_in[ref_clk_select];

    // Counts consecutive cycles in which the PLL is held in reset.
    always_ff @(posedge clk) begin
        if (srst || pll_reset_n) begin
            low_cnt_ff <= 8'h00;
        end else if (low_cnt_ff != 8'hff) begin
            low_cnt_ff <= low_cnt_ff + 8'h01;
        end
    end

    // Counts cycles since the selected reference last changed level.
    always_ff @(posedge clk) begin
        ref_prev_ff <= ref_sel;
        if (srst || (ref_sel != ref_prev_ff)) begin
            gap_cnt_ff <= 8'h00;
        end else if (gap_cnt_ff != 8'hff) begin
            gap_cnt_ff <= gap_cnt_ff + 8'h01;
        end
    end

    property p_lock_drop;
        $fell(pll_reset_n) |-> ##[1:4] !pll_locked;
    endproperty
    a_lock_drop: assert property (p_lock_drop)
        else $error("lock stayed high after reset was asserted");

    property p_lock_needs_run;
        $rose(pll_locked) |-> pll_reset_n && $past(pll_reset_n, 16);
    endproperty
    a_lock_needs_run: assert property (p_lock_needs_run)
        else $error("lock rose without a long enough run");

    property p_sel_in_reset;
        $changed(ref_clk_select) |-> !pll_reset_n;
    endproperty
    a_sel_in_reset: assert property (p_sel_in_reset)
        else $error("reference select changed while running");

    property p_settle;
        $rose(pll_reset_n) |-> low_cnt_ff >= REF_SETTLE_CYC;
    endproperty
    a_settle: assert property (p_settle)
        else $error("reset released before reference settled");

    property p_min_pulse;
        $fell(pll_reset_n) |=> !pll_reset_n;
    endproperty
    a_min_pulse: assert property (p_min_pulse)
        else $error("reset pulse too short");

    property p_fb_route;
        (core_feedback_clk == pll_out_clk_a) ||
        (core_feedback_clk == pll_out_clk_b);
    endproperty
    a_fb_route: assert property (p_fb_route)
        else $error("feedback clock is not an output clock");

    property p_gap_freeze;
        (gap_cnt_ff >= REF_GAP_CYC + 3) && pll_reset_n &&
        $past(pll_reset_n, 4) |-> $stable(pll_locked);
    endproperty
    a_gap_freeze: assert property (p_gap_freeze)
        else $error("lock changed while reference was silent");

    property p_out_quiet;
        !pll_reset_n [*5] |->
            !pll_out_clk_a && !pll_out_clk_b && !pll_out_clk_c;
    endproperty
    a_out_quiet: assert property (p_out_quiet)
        else $error("output clock ran while PLL held in reset");

    // Main scenarios reached.
    c_lock: cover property ($rose(pll_locked));
    c_sel: cover property ($changed(ref_clk_select));
    c_run: cover property ($rose(pll_reset_n));
endmodule // pll_link_properties

//--- testbench/tb_top.sv
// Testbench joining the PLL device and fabric ends over their link.
`timescale 1ns/1ps
module tb_top
    import pll_pkg::*;
;
    logic        clk, srst, psel, penable, pwrite, pready, pslverr, rerr;
    logic [3:0]  refs, ref_run, pre_n, post_o;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  mult_m;
    logic [8:0]  div_c;
    logic [2:0]  out_enable;
    logic [1:0]  fb_select, active_source;
    logic        config_ok, phase_aligned, prev_b;
    src_mode_e   src_mode;
    fb_mode_e    fb_mode;
    phase_e      phase_a;
    int          ref_cnt [4];
    int          err_total, num_checks, tog;

    pll_link_if link ();
    assign link.ref_clk_in = refs;

    pll_device pll_device_i (.clk(clk), .srst(srst), .link(link),
        .src_mode(src_mode), .fb_mode(fb_mode), .fb_select(fb_select),
        .mult_m(mult_m), .pre_n(pre_n), .post_o(post_o), .div_c(div_c),
        .out_enable(out_enable), .phase_a(phase_a), .config_ok(config_ok),
        .phase_aligned(phase_aligned), .active_source(active_source));
    pll_fabric_ctrl pll_fabric_ctrl_i (.clk(clk), .srst(srst), .link(link),
        .ref_clk_src(refs), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    pll_link_properties props_i (.clk(clk), .srst(srst),
        .ref_clk_in(link.ref_clk_in), .ref_clk_select(link.ref_clk_select),
        .pll_reset_n(link.pll_reset_n),
        .core_feedback_clk(link.core_feedback_clk),
        .pll_locked(link.pll_locked), .pll_out_clk_a(link.pll_out_clk_a),
        .pll_out_clk_b(link.pll_out_clk_b), .pll_out_clk_c(link.pll_out_clk_c));

    // Clock of 40 ns period.
    always #20 clk = ~clk;

    // Reference i toggles every i%3+1 cycles, inside the running gap.
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (ref_run[i] && ref_cnt[i] >= i % 3) begin
                ref_cnt[i] <= 0;
                refs[i] <= ~refs[i];
            end else if (ref_run[i]) begin
                ref_cnt[i] <= ref_cnt[i] + 1;
            end
        end
    end

    task automatic report_and_stop();
        if (err_total == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer; read data and error land in rd and rerr.
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            err_total++;
            report_and_stop();
        end
    endtask

    // Reads status until it matches or the poll budget runs out.
    task automatic poll_status(input logic [31:0] e);
        int k;
        k = 0;
        do begin
            xfer(1'b0, 12'h004, 32'h0);
            k++;
        end while (rd !== e && k < 150);
        chk("status", e, rd);
    endtask

    function automatic logic [31:0] pick(input int w);
        if (w == 0) return {31'h0, config_ok};
        if (w == 1) return {30'h0, active_source};
        return {31'h0, phase_aligned};
    endfunction

    // Waits a bounded time for a registered level, then compares it.
    task automatic settle_chk(input string nm, input logic [31:0] e,
                              input int w);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pick(w) !== e && k < 12);
        chk(nm, e, pick(w));
    endtask

    // Legal divider and phase settings worked out from the ranges.
    function automatic logic exp_ok(logic [7:0] m, logic [3:0] n,
        logic [3:0] o, logic [8:0] c, logic [2:0] en, phase_e ph);
        logic ph_ok;
        ph_ok = (ph == PH_0) ||
            (c == 9'h002 && ph inside {PH_90, PH_180, PH_270}) ||
            (c == 9'h004 && ph inside {PH_45, PH_90, PH_135}) ||
            (c == 9'h006 && ph == PH_90);
        return m != 8'h00 && n != 4'h0 && o inside {4'h1, 4'h2, 4'h4, 4'h8}
            && c != 9'h000 && c <= 9'h100 && ph_ok
            && !(o == 4'h1 && en != 3'b001 && en != 3'b010 && en != 3'b100);
    endfunction

    task automatic try_cfg(logic [7:0] m, logic [3:0] n, logic [3:0] o,
                           logic [8:0] c, logic [2:0] en, phase_e ph);
        @(posedge clk);
        mult_m <= m;
        pre_n <= n;
        post_o <= o;
        div_c <= c;
        out_enable <= en;
        phase_a <= ph;
        settle_chk("config_ok", {31'h0, exp_ok(m, n, o, c, en, ph)}, 0);
    endtask

    // Main sequence.
    initial begin
        {clk, psel, penable, pwrite, paddr, pwdata, refs} = '0;
        {fb_select, err_total, num_checks} = '0;
        ref_cnt = '{0, 0, 0, 0};
        ref_run = 4'hf;
        srst = 1'b1;
        src_mode = SRC_DYNAMIC;
        fb_mode = FB_INTERNAL;
        {mult_m, pre_n, post_o, div_c} = {8'h04, 4'h1, POST_2, CDIV_2};
        out_enable = 3'b111;
        phase_a = PH_90;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        chk("pll_reset_n_after_reset", 32'h0, {31'h0, link.pll_reset_n});
        xfer(1'b0, 12'h000, 32'h0);
        chk("ctrl_reset", 32'h0, rd);
        poll_status(32'h0);
        xfer(1'b1, 12'h010, 32'h0000_0033);
        chk("wr_unmapped_err", 32'h1, {31'h0, rerr});
        xfer(1'b0, 12'h010, 32'h0);
        chk("rd_unmapped", 32'h1, {rd[30:0], rerr});
        xfer(1'b1, 12'h000, 32'h0000_0032);
        xfer(1'b0, 12'h000, 32'h0);
        chk("ctrl_rw", 32'h0000_0032, rd);
        try_cfg(8'h01, 4'h1, POST_1, 9'h001, 3'b001, PH_0);
        try_cfg(8'hff, 4'hf, POST_8, 9'h100, 3'b111, PH_0);
        try_cfg(8'h00, 4'h1, POST_2, 9'h001, 3'b111, PH_0);
        try_cfg(8'h04, 4'h0, POST_2, 9'h001, 3'b111, PH_0);
        try_cfg(8'h04, 4'h1, 4'h3, 9'h001, 3'b111, PH_0);
        try_cfg(8'h04, 4'h1, POST_1, 9'h001, 3'b011, PH_0);
        try_cfg(8'h04, 4'h1, POST_4, 9'h000, 3'b111, PH_0);
        try_cfg(8'h04, 4'h1, POST_4, 9'h101, 3'b111, PH_0);
        try_cfg(8'h04, 4'h1, POST_2, CDIV_2, 3'b111, PH_270);
        try_cfg(8'h04, 4'h1, POST_2, CDIV_2, 3'b111, PH_45);
        try_cfg(8'h04, 4'h1, POST_2, CDIV_4, 3'b111, PH_135);
        try_cfg(8'h04, 4'h1, POST_2, CDIV_4, 3'b111, PH_45);
        try_cfg(8'h04, 4'h1, POST_2, CDIV_4, 3'b111, PH_180);
        try_cfg(8'h04, 4'h1, POST_2, CDIV_6, 3'b111, PH_90);
        try_cfg(8'h04, 4'h1, POST_2, CDIV_6, 3'b111, PH_135);
        try_cfg(8'h04, 4'h1, POST_2, 9'h003, 3'b111, PH_90);
        src_mode <= SRC_EXTERNAL;
        settle_chk("src_pad", {30'h0, EXT_PAD_IDX}, 1);
        src_mode <= SRC_CORE;
        settle_chk("src_core", {30'h0, CORE_CLK_IDX}, 1);
        src_mode <= SRC_DYNAMIC;
        settle_chk("src_dyn", 32'h3, 1);
        try_cfg(8'h04, 4'h1, POST_2, CDIV_2, 3'b111, PH_90);
        fb_mode <= FB_LOCAL;
        for (int s = 0; s < 4; s++) begin
            xfer(1'b1, 12'h000, {26'h0, s[1:0], 4'h1});
            poll_status({27'h0, s[1:0], 3'b111});
            chk("select_pin", s, {30'h0, link.ref_clk_select});
            settle_chk("src_sel", s, 1);
            settle_chk("aligned_local", 32'h1, 2);
        end
        ref_run <= 4'h7;
        repeat (40) @(posedge clk);
        chk("lock_frozen_high", 32'h1, {31'h0, link.pll_locked});
        ref_run <= 4'hf;
        out_enable <= 3'b011;
        fb_select <= 2'h1;
        fb_mode <= FB_CORE;
        xfer(1'b1, 12'h000, 32'h0000_0033);
        settle_chk("aligned_core", 32'h1, 2);
        tog = 0;
        prev_b = link.pll_out_clk_b;
        repeat (60) begin
            @(posedge clk);
            chk("fb_is_b", {31'h0, link.pll_out_clk_b},
                {31'h0, link.core_feedback_clk});
            chk("out_c_off", 32'h0, {31'h0, link.pll_out_clk_c});
            tog += (link.pll_out_clk_b !== prev_b) ? 1 : 0;
            prev_b = link.pll_out_clk_b;
        end
        chk("out_b_runs", 32'h1, {31'h0, tog > 0});
        fb_mode <= FB_INTERNAL;
        settle_chk("aligned_int", 32'h0, 2);
        xfer(1'b1, 12'h000, 32'h0);
        poll_status(32'h0);
        ref_run <= 4'h0;
        xfer(1'b1, 12'h000, 32'h0000_0001);
        poll_status(32'h0000_0006);
        repeat (60) @(posedge clk);
        chk("lock_frozen_low", 32'h0, {31'h0, link.pll_locked});
        report_and_stop();
    end
endmodule // tb_top
